// [verilog/expo_sync_pkg.sv]
// constants, types and register map of the exposure latch and readback bank
package expo_sync_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_LATCH_CONTROL = 8'h0E;
    localparam logic [7:0] IDX_TIMER_GRAN = 8'h10;
    localparam logic [7:0] IDX_CLEAR_DUR = 8'h11;
    localparam logic [7:0] IDX_INTEG_TIME = 8'h12;
    localparam logic [7:0] IDX_SPARE_A = 8'h13;
    localparam logic [7:0] IDX_SPARE_B = 8'h14;
    localparam logic [7:0] IDX_ANALOG_AMP = 8'h15;
    localparam logic [7:0] IDX_DIG_MULT = 8'h16;
    localparam logic [7:0] IDX_SPARE_C = 8'h18;

    // field positions in the latch control register
    localparam int FRAME_ALIGN_BIT = 3;
    localparam int LATCH_POLICY_BIT = 10;

    // field positions in the analog amplifier readback
    localparam int COL_AMP_LSB = 0;
    localparam int COL_AMP_MSB = 4;
    localparam int FE_AMP_LSB = 5;
    localparam int FE_AMP_MSB = 12;

    // reset values
    localparam logic [15:0] LATCH_CONTROL_RST = 16'h0008;
    localparam logic [15:0] READBACK_RST = 16'h0000;
    localparam logic [15:0] SPARE_C_RST = 16'h7f00;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // access timing: cycles the access phase lasts before pready
    localparam int ACCESS_WAIT_CYCLES = 1;

    // sequencer operating modes
    typedef enum logic [1:0] {
        MODE_ROLLING = 2'b00,
        MODE_GS_PIPELINED = 2'b01,
        MODE_GS_TRIG_MASTER = 2'b10,
        MODE_SLAVE = 2'b11
    } op_mode_e;

    // exposure and amplifier parameter set
    typedef struct packed {
        logic [15:0] timer_granularity;
        logic [15:0] clear_duration;
        logic [15:0] integration_time;
        logic [4:0] column_amp;
        logic [7:0] front_end_amp;
        logic [11:0] digital_multiplier;
    } param_s;

    // sequencer phase markers, one-cycle pulses
    typedef struct packed {
        logic frame_overhead_phase;
        logic exposure_end_phase;
    } phase_s;

endpackage

// [verilog/expo_latch_ctrl.sv]
// decides the cycle on which pending exposure parameters are applied
`timescale 1ns/100ps

module expo_latch_ctrl (
    input wire logic clk, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    input expo_sync_pkg::op_mode_e op_mode, // current sequencer mode
    input wire logic frame_align, // exposure frame-align enable
    input wire logic latch_policy, // exposure latch policy bit
    input expo_sync_pkg::phase_s phase, // phase start pulses
    input wire logic param_written, // new parameters were written
    output logic apply, // take parameters this cycle
    output logic pending // parameters waiting to be applied
);

    logic pending_q;
    logic phase_hit;
    logic want;

    // the phase that closes the wait depends on the mode
    always_comb begin
        if (op_mode == expo_sync_pkg::MODE_GS_TRIG_MASTER) begin
            phase_hit = phase.exposure_end_phase;
        end else begin
            phase_hit = phase.frame_overhead_phase;
        end
    end

    // with frame-align set, policy set applies on any cycle, cleared waits for the phase
    assign want = pending_q | param_written;
    assign apply = frame_align & want & (latch_policy | phase_hit);

    // pending flag: a write in the apply cycle is taken with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (apply) begin
            pending_q <= 1'b0;
        end else if (param_written) begin
            pending_q <= 1'b1;
        end
    end

    assign pending = pending_q;

endmodule

// [verilog/expo_sync_top.sv]
// exposure latch policy and applied-parameter readback bank with apb slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// - policy cleared: new exposure values take effect at frame overhead start
// - policy set: exposure values apply continuously as they are written
// - triggered global master mode latches at exposure end start instead
// - frame-align enable cleared still postpones exposure updates
// - timer granularity in use readable, valid only in master global modes
// - pixel clear duration in use readable, not updated in slave mode
// - exposure time in use readable, not updated in slave mode
// - amplifier settings in bits 4..0 and 12..5, multiplier in 11..0
// - frame-align enable cleared: updates are held and none apply until it is set again
module expo_sync_top (
    input wire logic CLK, // system clock, 125 MHz
    input wire logic RSTN, // asynchronous reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high for write
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    input expo_sync_pkg::op_mode_e OP_MODE, // sequencer operating mode
    input expo_sync_pkg::phase_s PHASE, // phase start pulses
    input wire logic PARAM_WRITTEN, // new parameter set written, pulse
    input expo_sync_pkg::param_s PARAM_IN, // latest written parameter set
    output expo_sync_pkg::param_s APPLIED, // parameter set in use
    output logic APPLY_STROBE, // pulse when parameters were applied
    output logic UPDATE_PENDING // parameters waiting for their latch point
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////////

    logic [15:0] latch_control_q;
    logic [15:0] spare_c_q;
    logic [15:0] timer_gran_q;
    logic [15:0] clear_dur_q;
    logic [15:0] integ_time_q;
    logic [4:0] column_amp_q;
    logic [7:0] front_end_amp_q;
    logic [11:0] dig_mult_q;
    expo_sync_pkg::param_s applied_q;
    logic apply_strobe_q;
    logic pending_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic pslverr_d;
    logic access;
    logic wr_done;
    logic rd_done;
    logic [7:0] reg_idx;
    logic apply;
    logic pending;
    logic frame_align;
    logic latch_policy;
    logic master_gs;
    logic not_slave;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////////////////

    // true when a word index falls on a mapped register
    function automatic logic is_mapped(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        unique case (idx)
            expo_sync_pkg::IDX_LATCH_CONTROL,
            expo_sync_pkg::IDX_TIMER_GRAN,
            expo_sync_pkg::IDX_CLEAR_DUR,
            expo_sync_pkg::IDX_INTEG_TIME,
            expo_sync_pkg::IDX_SPARE_A,
            expo_sync_pkg::IDX_SPARE_B,
            expo_sync_pkg::IDX_ANALOG_AMP,
            expo_sync_pkg::IDX_DIG_MULT,
            expo_sync_pkg::IDX_SPARE_C: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // merge write data into a 16-bit register under byte strobes
    function automatic logic [15:0] strobe_merge(input logic [15:0] old, input logic [31:0] wdata,
                                                 input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb access decode
    ////////////////////////////////////////////////////////////////////////////

    // word index from the byte address; the two low bits are ignored
    assign reg_idx = PADDR[9:2];

    // access phase before pready; the transfer is answered on the cycle pready is high
    assign access = PSEL & PENABLE & ~pready_q;
    assign wr_done = PSEL & PENABLE & pready_q & PWRITE;
    assign rd_done = PSEL & PENABLE & pready_q & ~PWRITE;

    // pready raised one cycle into the access phase, for one cycle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access;
        end
    end

    // read mux; read-only and spare words return zero above bit 15
    always_comb begin
        prdata_d = expo_sync_pkg::PRDATA_RST;
        unique case (reg_idx)
            expo_sync_pkg::IDX_LATCH_CONTROL: prdata_d[15:0] = latch_control_q;
            expo_sync_pkg::IDX_TIMER_GRAN: prdata_d[15:0] = timer_gran_q;
            expo_sync_pkg::IDX_CLEAR_DUR: prdata_d[15:0] = clear_dur_q;
            expo_sync_pkg::IDX_INTEG_TIME: prdata_d[15:0] = integ_time_q;
            expo_sync_pkg::IDX_ANALOG_AMP: begin
                prdata_d[expo_sync_pkg::COL_AMP_MSB:expo_sync_pkg::COL_AMP_LSB] = column_amp_q;
                prdata_d[expo_sync_pkg::FE_AMP_MSB:expo_sync_pkg::FE_AMP_LSB] = front_end_amp_q;
            end
            expo_sync_pkg::IDX_DIG_MULT: prdata_d[11:0] = dig_mult_q;
            expo_sync_pkg::IDX_SPARE_C: prdata_d[15:0] = spare_c_q;
            default: prdata_d = expo_sync_pkg::PRDATA_RST;
        endcase
    end

    // error only for unmapped words
    assign pslverr_d = ~is_mapped(reg_idx);

    // read data and error captured with pready
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            prdata_q <= expo_sync_pkg::PRDATA_RST;
            pslverr_q <= 1'b0;
        end else if (access) begin
            prdata_q <= PWRITE ? expo_sync_pkg::PRDATA_RST : prdata_d;
            pslverr_q <= pslverr_d;
        end else begin
            prdata_q <= expo_sync_pkg::PRDATA_RST;
            pslverr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable registers
    ////////////////////////////////////////////////////////////////////////////

    // latch control word; only the two documented bits are kept
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            latch_control_q <= expo_sync_pkg::LATCH_CONTROL_RST;
        end else if (wr_done && reg_idx == expo_sync_pkg::IDX_LATCH_CONTROL) begin
            latch_control_q <= strobe_merge(latch_control_q, PWDATA, PSTRB)
                & ((16'h0001 << expo_sync_pkg::FRAME_ALIGN_BIT) | (16'h0001 << expo_sync_pkg::LATCH_POLICY_BIT));
        end
    end

    // spare writable word, plain storage
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            spare_c_q <= expo_sync_pkg::SPARE_C_RST;
        end else if (wr_done && reg_idx == expo_sync_pkg::IDX_SPARE_C) begin
            spare_c_q <= strobe_merge(spare_c_q, PWDATA, PSTRB);
        end
    end

    assign frame_align = latch_control_q[expo_sync_pkg::FRAME_ALIGN_BIT];
    assign latch_policy = latch_control_q[expo_sync_pkg::LATCH_POLICY_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // latch point
    ////////////////////////////////////////////////////////////////////////////

    // chooses the apply cycle from mode, policy and frame-align enable
    expo_latch_ctrl u_latch (
        .clk(CLK),
        .rst_n(RSTN),
        .op_mode(OP_MODE),
        .frame_align(frame_align),
        .latch_policy(latch_policy),
        .phase(PHASE),
        .param_written(PARAM_WRITTEN),
        .apply(apply),
        .pending(pending)
    );

    // modes in which readbacks refresh
    assign master_gs = (OP_MODE == expo_sync_pkg::MODE_GS_PIPELINED) ||
                       (OP_MODE == expo_sync_pkg::MODE_GS_TRIG_MASTER);
    assign not_slave = (OP_MODE != expo_sync_pkg::MODE_SLAVE);

    // parameter set handed to the sequencer on apply
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            applied_q <= '0;
        end else if (apply) begin
            applied_q <= PARAM_IN;
        end
    end

    // apply pulse and pending level toward the sequencer
    // pending mirrors the next wait state so it lines up with the strobe
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            apply_strobe_q <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            apply_strobe_q <= apply;
            pending_q <= ~apply & (pending | PARAM_WRITTEN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback registers, refreshed only when values are applied
    ////////////////////////////////////////////////////////////////////////////

    // timer granularity follows only in master global shutter modes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            timer_gran_q <= expo_sync_pkg::READBACK_RST;
        end else if (apply && master_gs) begin
            timer_gran_q <= PARAM_IN.timer_granularity;
        end
    end

    // clear duration and exposure time frozen in slave mode
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            clear_dur_q <= expo_sync_pkg::READBACK_RST;
            integ_time_q <= expo_sync_pkg::READBACK_RST;
        end else if (apply && not_slave) begin
            clear_dur_q <= PARAM_IN.clear_duration;
            integ_time_q <= PARAM_IN.integration_time;
        end
    end

    // amplifier and multiplier settings follow every apply
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            column_amp_q <= '0;
            front_end_amp_q <= '0;
            dig_mult_q <= '0;
        end else if (apply) begin
            column_amp_q <= PARAM_IN.column_amp;
            front_end_amp_q <= PARAM_IN.front_end_amp;
            dig_mult_q <= PARAM_IN.digital_multiplier;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////////

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign APPLIED = applied_q;
    assign APPLY_STROBE = apply_strobe_q;
    assign UPDATE_PENDING = pending_q;

endmodule

// [dv/expo_sync_properties.sv]
// port assertions for the exposure latch bank
`timescale 1ns/100ps
module expo_sync_checker (
    input wire logic CLK, // clock
    input wire logic RSTN, // reset, active low
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // write
    input wire logic [11:0] PADDR, // address
    input wire logic [31:0] PWDATA, // write data
    input wire logic [3:0] PSTRB, // strobes
    input wire logic [31:0] PRDATA, // read data
    input wire logic PREADY, // ready
    input wire logic PSLVERR, // error
    input expo_sync_pkg::op_mode_e OP_MODE, // mode
    input expo_sync_pkg::phase_s PHASE, // phase pulses
    input wire logic PARAM_WRITTEN, // write pulse
    input expo_sync_pkg::param_s APPLIED, // set in use
    input wire logic APPLY_STROBE, // apply pulse
    input wire logic UPDATE_PENDING // waiting set
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic [15:0] ctl_q;
    logic hit;
    ////////////////////////////////////////////////////////////
    // shadow of the latch control register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_q <= expo_sync_pkg::LATCH_CONTROL_RST;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR[9:2] == expo_sync_pkg::IDX_LATCH_CONTROL) begin
            ctl_q <= {PSTRB[1] ? PWDATA[15:8] : ctl_q[15:8], PSTRB[0] ? PWDATA[7:0] : ctl_q[7:0]};
        end
    end
    // latch point of the current mode
    assign hit = OP_MODE == expo_sync_pkg::MODE_GS_TRIG_MASTER ? PHASE.exposure_end_phase : PHASE.frame_overhead_phase;
    ////////////////////////////////////////////////////////////
    property p_one_wait;
        PSEL && $rose(PENABLE) |=> PREADY;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not after one wait state");
    property p_err_data;
        PSLVERR |-> PREADY && PRDATA == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error outside ready or with data");
    property p_idle_data;
        !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside ready");
    property p_hold;
        $changed(APPLIED) |-> APPLY_STROBE;
    endproperty
    a_hold: assert property (p_hold) else $error("applied set moved without apply");
    property p_cause;
        APPLY_STROBE |-> $past(PARAM_WRITTEN) || $past(UPDATE_PENDING);
    endproperty
    a_cause: assert property (p_cause) else $error("apply with nothing written");
    property p_cont;
        ctl_q[3] && ctl_q[10] && PARAM_WRITTEN |=> APPLY_STROBE;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous update not applied");
    property p_wait;
        ctl_q[3] && !ctl_q[10] && !hit && PARAM_WRITTEN |=> !APPLY_STROBE;
    endproperty
    a_wait: assert property (p_wait) else $error("applied off the latch point");
    property p_phase;
        ctl_q[3] && !ctl_q[10] && hit && PARAM_WRITTEN |=> APPLY_STROBE;
    endproperty
    a_phase: assert property (p_phase) else $error("not applied at the latch point");
    property p_freeze;
        !ctl_q[3] |=> !APPLY_STROBE;
    endproperty
    a_freeze: assert property (p_freeze) else $error("applied while alignment cleared");
    property p_pend;
        !ctl_q[3] && PARAM_WRITTEN |=> UPDATE_PENDING;
    endproperty
    a_pend: assert property (p_pend) else $error("write not held while alignment cleared");
endmodule
bind expo_sync_top expo_sync_checker u_expo_sync_checker (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB, .PRDATA, .PREADY, .PSLVERR, .OP_MODE, .PHASE, .PARAM_WRITTEN, .APPLIED, .APPLY_STROBE, .UPDATE_PENDING);

// [dv/testbench.sv]
// self-checking bench for the exposure latch and readback bank
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PARAM_WRITTEN = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [3:0] PSTRB = 4'hF;
    expo_sync_pkg::op_mode_e OP_MODE = expo_sync_pkg::MODE_ROLLING;
    expo_sync_pkg::phase_s PHASE = 2'b00;
    expo_sync_pkg::param_s PARAM_IN = '0;
    expo_sync_pkg::param_s APPLIED;
    logic [31:0] PRDATA, rdat;
    logic PREADY, PSLVERR, APPLY_STROBE, UPDATE_PENDING, rerr;
    logic [15:0] e_tg = 16'h0000, e_cd = 16'h0000, e_it = 16'h0000;
    int failures = 0, checks = 0, cyc = 0;
    expo_sync_top u_expo_sync_top (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY,
        .PSLVERR, .OP_MODE, .PHASE, .PARAM_WRITTEN, .PARAM_IN, .APPLIED, .APPLY_STROBE, .UPDATE_PENDING);
    // clock and run limit
    always #4 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // distinct parameter set per tag
    function automatic expo_sync_pkg::param_s mk(input logic [3:0] k);
        mk = {4'h1, k, 8'h5A, 4'h2, k, 8'hC3, 4'h3, k, 8'h96, 1'b1, k, k, 4'h9, k, 8'h6E};
    endfunction
    // one apb transfer, held until ready
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [15:0] wd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= {2'b00, idx, 2'b00};
        PWDATA <= {16'h0000, wd};
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) begin
            @(posedge CLK);
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp, input logic err);
        apb(idx, 1'b0, 16'h0000);
        `CHK(rdat, {16'h0000, exp});
        `CHK(rerr, err);
    endtask
    // parameter write and phase pulses for one cycle
    task automatic ev(input logic [3:0] k, input logic w, input logic fo, input logic ee);
        @(posedge CLK);
        PARAM_IN <= mk(k);
        PARAM_WRITTEN <= w;
        PHASE <= {fo, ee};
        @(posedge CLK);
        PARAM_WRITTEN <= 1'b0;
        PHASE <= 2'b00;
    endtask
    task automatic see(input expo_sync_pkg::param_s p, input logic s);
        @(negedge CLK);
        `CHK(APPLIED, p);
        `CHK(APPLY_STROBE, s);
        `CHK(UPDATE_PENDING, !s);
    endtask
    // readbacks after an apply in the current mode
    task automatic upd(input expo_sync_pkg::param_s p);
        if (OP_MODE inside {expo_sync_pkg::MODE_GS_PIPELINED, expo_sync_pkg::MODE_GS_TRIG_MASTER}) begin
            e_tg = p.timer_granularity;
        end
        if (OP_MODE != expo_sync_pkg::MODE_SLAVE) begin
            e_cd = p.clear_duration;
            e_it = p.integration_time;
        end
        rd(8'h10, e_tg, 1'b0);
        rd(8'h11, e_cd, 1'b0);
        rd(8'h12, e_it, 1'b0);
        rd(8'h15, {3'b000, p.front_end_amp, p.column_amp}, 1'b0);
        rd(8'h16, {4'h0, p.digital_multiplier}, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        // reset values, write protection, unmapped index
        rd(8'h0E, 16'h0008, 1'b0);
        rd(8'h18, 16'h7F00, 1'b0);
        for (int i = 14; i < 25; i++) begin
            apb(8'(i), 1'b1, 16'hFFFF);
        end
        for (int i = 15; i < 24; i++) begin
            rd(8'(i), 16'h0000, i == 15 || i == 23);
        end
        rd(8'h18, 16'hFFFF, 1'b0);
        rd(8'h0E, 16'h0408, 1'b0);
        apb(8'h0E, 1'b1, 16'h0008);
        // rolling mode waits for frame overhead start
        ev(4'h1, 1'b1, 1'b0, 1'b0);
        see('0, 1'b0);
        ev(4'h1, 1'b0, 1'b0, 1'b1);
        see('0, 1'b0);
        ev(4'h1, 1'b0, 1'b1, 1'b0);
        see(mk(4'h1), 1'b1);
        upd(mk(4'h1));
        // triggered master latches at exposure end
        @(posedge CLK);
        OP_MODE <= expo_sync_pkg::MODE_GS_TRIG_MASTER;
        ev(4'h2, 1'b1, 1'b1, 1'b0);
        see(mk(4'h1), 1'b0);
        ev(4'h2, 1'b0, 1'b0, 1'b1);
        see(mk(4'h2), 1'b1);
        upd(mk(4'h2));
        // policy set, then alignment cleared
        apb(8'h0E, 1'b1, 16'h0408);
        ev(4'h3, 1'b1, 1'b0, 1'b0);
        see(mk(4'h3), 1'b1);
        apb(8'h0E, 1'b1, 16'h0400);
        ev(4'h4, 1'b1, 1'b1, 1'b1);
        see(mk(4'h3), 1'b0);
        apb(8'h0E, 1'b1, 16'h0408);
        @(posedge CLK);
        see(mk(4'h4), 1'b1);
        upd(mk(4'h4));
        apb(8'h0E, 1'b1, 16'h0008);
        // slave mode, then pipelined mode, each with a write on the latch point
        @(posedge CLK);
        OP_MODE <= expo_sync_pkg::MODE_SLAVE;
        ev(4'h5, 1'b1, 1'b1, 1'b0);
        see(mk(4'h5), 1'b1);
        upd(mk(4'h5));
        @(posedge CLK);
        OP_MODE <= expo_sync_pkg::MODE_GS_PIPELINED;
        ev(4'h6, 1'b1, 1'b1, 1'b0);
        see(mk(4'h6), 1'b1);
        upd(mk(4'h6));
        end_of_test();
    end
endmodule
